// ===== src/itf_consts.vh
// constants for the instruction timing and flag unit
// assumes a word-aligned register port with 8-bit byte addresses
`ifndef ITF_CONSTS_VH
`define ITF_CONSTS_VH

// register byte addresses
`define ITF_REG_CMD   8'h00
`define ITF_REG_OPND  8'h04
`define ITF_REG_ACC   8'h08
`define ITF_REG_STAT  8'h0C
`define ITF_REG_RES   8'h10
`define ITF_REG_TBL   8'h14
`define ITF_REG_CYC   8'h18
`define ITF_REG_PC    8'h1C
`define ITF_REG_CTRL  8'h20

// command word fields
`define ITF_CMD_OP_LSB   0
`define ITF_CMD_BIT_LSB  8
`define ITF_CMD_PCL_BIT  11
`define ITF_CMD_ADDR_LSB 16

// status word bits
`define ITF_ST_BUSY  0
`define ITF_ST_CARRY 1
`define ITF_ST_TO    2
`define ITF_ST_PDF   3
`define ITF_ST_SKIP  4
`define ITF_ST_HALT  5
`define ITF_ST_PRE1  6
`define ITF_ST_PRE2  7
`define ITF_ST_MEMWR 8

// control word bits
`define ITF_CT_WAKE  0
`define ITF_CT_CVAL  1
`define ITF_CT_CLD   2

// reset values
`define ITF_RST_ACC  8'h00
`define ITF_RST_PC   13'h0000

// timing
`define ITF_CLKS_PER_MCYCLE 3'h4
`define ITF_LAST_PAGE       5'h1F

// instruction codes
`define ITF_OP_NOP    6'h00
`define ITF_OP_RR     6'h01
`define ITF_OP_RRA    6'h02
`define ITF_OP_RRC    6'h03
`define ITF_OP_RRCA   6'h04
`define ITF_OP_RL     6'h05
`define ITF_OP_RLA    6'h06
`define ITF_OP_RLC    6'h07
`define ITF_OP_RLCA   6'h08
`define ITF_OP_MOVAM  6'h09
`define ITF_OP_MOVMA  6'h0A
`define ITF_OP_MOVAX  6'h0B
`define ITF_OP_CLRB   6'h0C
`define ITF_OP_SETB   6'h0D
`define ITF_OP_JMP    6'h0E
`define ITF_OP_SZ     6'h0F
`define ITF_OP_SZA    6'h10
`define ITF_OP_SZB    6'h11
`define ITF_OP_SNZB   6'h12
`define ITF_OP_SIZ    6'h13
`define ITF_OP_SDZ    6'h14
`define ITF_OP_SIZA   6'h15
`define ITF_OP_SDZA   6'h16
`define ITF_OP_CALL   6'h17
`define ITF_OP_RET    6'h18
`define ITF_OP_RETAX  6'h19
`define ITF_OP_INTERRUPT_RETURN   6'h1A
`define ITF_OP_TRDC   6'h1B
`define ITF_OP_TRDL   6'h1C
`define ITF_OP_CLRM   6'h1D
`define ITF_OP_SETM   6'h1E
`define ITF_OP_CLRWDT 6'h1F
`define ITF_OP_WDT1   6'h20
`define ITF_OP_WDT2   6'h21
`define ITF_OP_SWAP   6'h22
`define ITF_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR  6'h23
`define ITF_OP_HALT   6'h24

`endif

// ===== src/itf_core.v
// instruction decode, cycle timing and flag handling for an 8-bit core
// assumes a single-cycle register port; read data one clock after strobe
`timescale 1ns/1ps
`include "itf_consts.vh"

module itf_core
(
  // clock and reset
  input  wire        CLK,
  input  wire        RESETN,
  // register port
  input  wire [7:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [31:0] RDATA,
  // watchdog side
  input  wire        WDT_TIMEOUT,
  output reg         WDT_CLEAR,
  output reg         PRESCALER_CLEAR,
  output reg         CLK_STOP,
  // program memory side
  output reg  [12:0] TABLE_ADDR
);

  // architectural state
  reg [7:0]  working_accumulator;
  reg [7:0]  operand;
  reg [7:0]  result;
  reg [15:0] rom_word;
  reg [7:0]  table_high_latch;
  reg [12:0] pc;
  reg [12:0] ret_addr;
  reg        carry;
  reg        watchdog_timeout_flag;
  reg        powerdown_flag;
  reg        pre1_seen;
  reg        pre2_seen;
  reg        skip_taken;
  reg        mem_written;
  reg [3:0]  clk_count;

  // command fields held for command register readback
  reg [5:0]  op;
  reg [2:0]  bit_idx;
  reg        pcl_target;
  reg [12:0] jump_addr;

  wire       busy;
  wire       start;
  wire       cmd_wr;
  wire [5:0] w_op;
  wire [2:0] w_bit;
  wire       w_pcl;
  wire [7:0] bit_mask;

  assign cmd_wr = WR && (ADDR == `ITF_REG_CMD);
  assign w_op   = WDATA[`ITF_CMD_OP_LSB +: 6];
  assign w_bit  = WDATA[`ITF_CMD_BIT_LSB +: 3];
  assign w_pcl  = WDATA[`ITF_CMD_PCL_BIT];
  // commands arriving while busy or clock-stopped are dropped
  assign start  = cmd_wr && !busy && !CLK_STOP;

  // one-hot bit selector for bit ops and bit tests, positions 0..7
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_mask
      assign bit_mask[gi] = (w_bit == gi);
    end
  endgenerate

  // two-cycle base group: jumps, calls, returns, table reads
  function is_two_cycle;
    input [5:0] o;
    begin
      case (o)
        `ITF_OP_JMP, `ITF_OP_CALL, `ITF_OP_RET,
        `ITF_OP_RETAX, `ITF_OP_INTERRUPT_RETURN,
        `ITF_OP_TRDC, `ITF_OP_TRDL: is_two_cycle = 1'b1;
        default: is_two_cycle = 1'b0;
      endcase
    end
  endfunction

  // instructions whose result goes back to data memory
  function writes_mem;
    input [5:0] o;
    begin
      case (o)
        `ITF_OP_RR, `ITF_OP_RRC, `ITF_OP_RL, `ITF_OP_RLC,
        `ITF_OP_MOVMA, `ITF_OP_CLRB, `ITF_OP_SETB,
        `ITF_OP_SIZ, `ITF_OP_SDZ, `ITF_OP_TRDC, `ITF_OP_TRDL,
        `ITF_OP_CLRM, `ITF_OP_SETM, `ITF_OP_SWAP: writes_mem = 1'b1;
        default: writes_mem = 1'b0;
      endcase
    end
  endfunction

  // decoded effects of the incoming command
  reg [7:0] next_res;
  reg [7:0] next_acc;
  reg       wr_acc;
  reg       next_carry;
  reg       next_skip;
  reg [7:0] inc_m;
  reg [7:0] dec_m;
  reg [1:0] next_mcyc;
  reg       pcl_pen;

  always @*
  begin
    inc_m      = operand + 8'h01;
    dec_m      = operand - 8'h01;
    next_res   = operand;
    next_acc   = working_accumulator;
    wr_acc     = 1'b0;
    next_carry = carry;
    next_skip  = 1'b0;
    case (w_op)
      // plain rotates leave carry alone
      `ITF_OP_RR:   next_res = {operand[0], operand[7:1]};
      `ITF_OP_RL:   next_res = {operand[6:0], operand[7]};
      `ITF_OP_RRA:
      begin
        next_acc = {operand[0], operand[7:1]};
        wr_acc   = 1'b1;
      end
      `ITF_OP_RLA:
      begin
        next_acc = {operand[6:0], operand[7]};
        wr_acc   = 1'b1;
      end
      // through-carry rotates shift the carry in and the dropped bit out to the carry
      `ITF_OP_RRC:
      begin
        next_res   = {carry, operand[7:1]};
        next_carry = operand[0];
      end
      `ITF_OP_RRCA:
      begin
        next_acc   = {carry, operand[7:1]};
        wr_acc     = 1'b1;
        next_carry = operand[0];
      end
      `ITF_OP_RLC:
      begin
        next_res   = {operand[6:0], carry};
        next_carry = operand[7];
      end
      `ITF_OP_RLCA:
      begin
        next_acc   = {operand[6:0], carry};
        wr_acc     = 1'b1;
        next_carry = operand[7];
      end
      // data moves; the operand doubles as immediate data
      `ITF_OP_MOVAM, `ITF_OP_MOVAX:
      begin
        next_acc = operand;
        wr_acc   = 1'b1;
      end
      `ITF_OP_MOVMA: next_res = working_accumulator;
      `ITF_OP_CLRB:  next_res = operand & ~bit_mask;
      `ITF_OP_SETB:  next_res = operand | bit_mask;
      // skips
      `ITF_OP_SZ:   next_skip = (operand == 8'h00);
      `ITF_OP_SZA:
      begin
        next_acc  = operand;
        wr_acc    = 1'b1;
        next_skip = (operand == 8'h00);
      end
      `ITF_OP_SZB:  next_skip = ((operand & bit_mask) == 8'h00);
      `ITF_OP_SNZB: next_skip = ((operand & bit_mask) != 8'h00);
      `ITF_OP_SIZ:
      begin
        next_res  = inc_m;
        next_skip = (inc_m == 8'h00);
      end
      `ITF_OP_SDZ:
      begin
        next_res  = dec_m;
        next_skip = (dec_m == 8'h00);
      end
      `ITF_OP_SIZA:
      begin
        next_acc  = inc_m;
        wr_acc    = 1'b1;
        next_skip = (inc_m == 8'h00);
      end
      `ITF_OP_SDZA:
      begin
        next_acc  = dec_m;
        wr_acc    = 1'b1;
        next_skip = (dec_m == 8'h00);
      end
      `ITF_OP_RETAX:
      begin
        next_acc = operand;
        wr_acc   = 1'b1;
      end
      // table reads: low byte to memory
      `ITF_OP_TRDC, `ITF_OP_TRDL: next_res = rom_word[7:0];
      `ITF_OP_CLRM: next_res = 8'h00;
      `ITF_OP_SETM: next_res = 8'hFF;
      `ITF_OP_SWAP: next_res = {operand[3:0], operand[7:4]};
      `ITF_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR:
      begin
        next_acc = {operand[3:0], operand[7:4]};
        wr_acc   = 1'b1;
      end
      default: next_res = operand;
    endcase
    // extra machine cycles stack: pc low load, then taken skip
    pcl_pen   = w_pcl && writes_mem(w_op);
    next_mcyc = (is_two_cycle(w_op) ? 2'd2 : 2'd1)
                + {1'b0, pcl_pen}
                + {1'b0, next_skip};
  end

  // machine-cycle timer; busy covers the whole stretched instruction
  itf_cycle_timer u_timer
  (
    .CLK     (CLK),
    .RESETN  (RESETN),
    .START   (start),
    .MCYCLES (next_mcyc),
    .BUSY    (busy),
    .DONE    ()
  );

  // program counter and return address
  always @(posedge CLK)
  begin
    if (!RESETN)
    begin
      pc       <= `ITF_RST_PC;
      ret_addr <= `ITF_RST_PC;
    end
    else if (start)
    begin
      case (w_op)
        `ITF_OP_JMP: pc <= WDATA[`ITF_CMD_ADDR_LSB +: 13];
        `ITF_OP_CALL:
        begin
          ret_addr <= pc + 13'h0001;
          pc       <= WDATA[`ITF_CMD_ADDR_LSB +: 13];
        end
        `ITF_OP_RET, `ITF_OP_RETAX, `ITF_OP_INTERRUPT_RETURN: pc <= ret_addr;
        default:
          if (pcl_pen)
            pc <= {pc[12:8], next_res};
          else if (next_skip)
            pc <= pc + 13'h0002;
          else
            pc <= pc + 13'h0001;
      endcase
    end
    else if (WR && ADDR == `ITF_REG_PC)
      pc <= WDATA[12:0];
  end

  // data path registers and result capture
  always @(posedge CLK)
  begin
    if (!RESETN)
    begin
      working_accumulator <= `ITF_RST_ACC;
      operand             <= 8'h00;
      result              <= 8'h00;
      rom_word            <= 16'h0000;
      table_high_latch    <= 8'h00;
      TABLE_ADDR          <= 13'h0000;
      op                  <= `ITF_OP_NOP;
      bit_idx             <= 3'h0;
      pcl_target          <= 1'b0;
      jump_addr           <= 13'h0000;
      skip_taken          <= 1'b0;
      mem_written         <= 1'b0;
      clk_count           <= 4'h0;
    end
    else if (start)
    begin
      op          <= w_op;
      bit_idx     <= w_bit;
      pcl_target  <= w_pcl;
      jump_addr   <= WDATA[`ITF_CMD_ADDR_LSB +: 13];
      result      <= next_res;
      mem_written <= writes_mem(w_op);
      skip_taken  <= next_skip;
      clk_count   <= {next_mcyc, 2'b00};
      if (wr_acc)
        working_accumulator <= next_acc;
      // current page from pc, last page fixed at the top
      if (w_op == `ITF_OP_TRDC)
      begin
        TABLE_ADDR       <= {pc[12:8], working_accumulator};
        table_high_latch <= rom_word[15:8];
      end
      if (w_op == `ITF_OP_TRDL)
      begin
        TABLE_ADDR       <= {`ITF_LAST_PAGE, working_accumulator};
        table_high_latch <= rom_word[15:8];
      end
    end
    else if (WR)
    begin
      if (ADDR == `ITF_REG_OPND)
        operand <= WDATA[7:0];
      if (ADDR == `ITF_REG_ACC)
        working_accumulator <= WDATA[7:0];
      if (ADDR == `ITF_REG_TBL)
        rom_word <= WDATA[15:0];
    end
  end

  // carry: only through-carry rotates or software touch it
  always @(posedge CLK)
  begin
    if (!RESETN)
      carry <= 1'b0;
    else if (start)
      carry <= next_carry;
    else if (WR && ADDR == `ITF_REG_CTRL && WDATA[`ITF_CT_CLD])
      carry <= WDATA[`ITF_CT_CVAL];
  end

  // watchdog flags; a timeout in the same cycle as a clear still sets
  reg next_to;
  reg next_pdf;
  reg next_pre1;
  reg next_pre2;
  reg next_wclr;

  always @*
  begin
    next_to   = watchdog_timeout_flag;
    next_pdf  = powerdown_flag;
    next_pre1 = pre1_seen;
    next_pre2 = pre2_seen;
    next_wclr = 1'b0;
    if (start)
    begin
      case (w_op)
        `ITF_OP_CLRWDT:
        begin
          next_to   = 1'b0;
          next_pdf  = 1'b0;
          next_wclr = 1'b1;
        end
        `ITF_OP_WDT1:
          if (pre2_seen)
          begin
            next_to   = 1'b0;
            next_pdf  = 1'b0;
            next_pre2 = 1'b0;
            next_wclr = 1'b1;
          end
          else
            next_pre1 = 1'b1;
        `ITF_OP_WDT2:
          if (pre1_seen)
          begin
            next_to   = 1'b0;
            next_pdf  = 1'b0;
            next_pre1 = 1'b0;
            next_wclr = 1'b1;
          end
          else
            next_pre2 = 1'b1;
        `ITF_OP_HALT:
        begin
          next_to   = 1'b0;
          next_pdf  = 1'b1;
          next_wclr = 1'b1;
        end
        default: next_wclr = 1'b0;
      endcase
    end
    if (WDT_TIMEOUT)
      next_to = 1'b1;
  end

  // flag registers and watchdog strobes
  always @(posedge CLK)
  begin
    if (!RESETN)
    begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag        <= 1'b0;
      pre1_seen             <= 1'b0;
      pre2_seen             <= 1'b0;
      WDT_CLEAR             <= 1'b0;
      PRESCALER_CLEAR       <= 1'b0;
      CLK_STOP              <= 1'b0;
    end
    else
    begin
      watchdog_timeout_flag <= next_to;
      powerdown_flag        <= next_pdf;
      pre1_seen             <= next_pre1;
      pre2_seen             <= next_pre2;
      WDT_CLEAR             <= next_wclr;
      PRESCALER_CLEAR       <= start && (w_op == `ITF_OP_HALT);
      // commands are refused while stopped; register-port writes still land
      if (start && w_op == `ITF_OP_HALT)
        CLK_STOP <= 1'b1;
      else if (WR && ADDR == `ITF_REG_CTRL && WDATA[`ITF_CT_WAKE])
        CLK_STOP <= 1'b0;
    end
  end

  // status word assembly
  wire [31:0] stat_word;
  assign stat_word = {23'h0, mem_written, pre2_seen, pre1_seen, CLK_STOP,
                      skip_taken, powerdown_flag, watchdog_timeout_flag,
                      carry, busy};

  // read port: captured at the strobe, stands one cycle, zero otherwise
  // unmapped addresses read as zero
  always @(posedge CLK)
  begin
    if (!RESETN)
      RDATA <= 32'h0;
    else if (RD)
    begin
      case (ADDR)
        `ITF_REG_CMD:
          RDATA <= {3'h0, jump_addr, 4'h0, pcl_target, bit_idx, 2'h0, op};
        `ITF_REG_OPND: RDATA <= {24'h0, operand};
        `ITF_REG_ACC:  RDATA <= {24'h0, working_accumulator};
        `ITF_REG_STAT: RDATA <= stat_word;
        `ITF_REG_RES:  RDATA <= {24'h0, result};
        `ITF_REG_TBL:  RDATA <= {24'h0, table_high_latch};
        `ITF_REG_CYC:  RDATA <= {28'h0, clk_count};
        `ITF_REG_PC:   RDATA <= {19'h0, pc};
        default:       RDATA <= 32'h0;
      endcase
    end
    else
      RDATA <= 32'h0;
  end

endmodule

// ===== src/itf_cycle_timer.v
// machine-cycle timer: holds busy for a count of machine cycles
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
`include "itf_consts.vh"

module itf_cycle_timer
(
  // clock and reset
  input  wire       CLK,
  input  wire       RESETN,
  // request
  input  wire       START,
  input  wire [1:0] MCYCLES,
  // state
  output wire       BUSY,
  output reg        DONE
);

  reg [3:0] remain;

  // load machine cycles times four, then count system clocks down
  always @(posedge CLK)
  begin
    if (!RESETN)
    begin
      remain <= 4'h0;
      DONE   <= 1'b0;
    end
    else if (START)
    begin
      remain <= {MCYCLES, 2'b00};
      DONE   <= 1'b0;
    end
    else if (remain != 4'h0)
    begin
      remain <= remain - 4'h1;
      DONE   <= (remain == 4'h1);
    end
    else
      DONE <= 1'b0;
  end

  assign BUSY = (remain != 4'h0);

endmodule

// ===== testbench/itf_core_props.sv
// port-level checker for the instruction timing and flag unit
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`include "itf_consts.vh"

module itf_core_props
(
  // clock and reset
  input wire        CLK,
  input wire        RESETN,
  // register port
  input wire [7:0]  ADDR,
  input wire [31:0] WDATA,
  input wire        WR,
  input wire        RD,
  input wire [31:0] RDATA,
  // watchdog and program memory side
  input wire        WDT_TIMEOUT,
  input wire        WDT_CLEAR,
  input wire        PRESCALER_CLEAR,
  input wire        CLK_STOP,
  input wire [12:0] TABLE_ADDR
);
  // decoded bus events, so past values are plain signals
  wire cmd_wr  = WR && (ADDR == `ITF_REG_CMD);
  wire halt_wr = cmd_wr && (WDATA[5:0] == `ITF_OP_HALT);
  wire trdl_wr = cmd_wr && (WDATA[5:0] == `ITF_OP_TRDL);
  wire tbl_wr  = trdl_wr || (cmd_wr && (WDATA[5:0] == `ITF_OP_TRDC));
  wire wake_wr = WR && (ADDR == `ITF_REG_CTRL) && WDATA[`ITF_CT_WAKE];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_wdclr_pulse: assert property (WDT_CLEAR |=> !WDT_CLEAR)
    else $error("watchdog clear longer than one cycle");
  a_wdclr_cause: assert property (WDT_CLEAR |-> $past(cmd_wr))
    else $error("watchdog clear without a command");
  a_presc_cause: assert property (PRESCALER_CLEAR |-> $past(halt_wr))
    else $error("prescaler clear without power-down");
  a_halt_effects: assert property (PRESCALER_CLEAR |-> WDT_CLEAR && CLK_STOP)
    else $error("power-down did not clear watchdog or stop clock");
  a_stop_cause: assert property ($rose(CLK_STOP) |-> $past(halt_wr))
    else $error("clock stopped without power-down");
  a_stop_hold: assert property (CLK_STOP && !wake_wr |=> CLK_STOP)
    else $error("clock restarted without wake");
  a_stop_wake: assert property ($fell(CLK_STOP) |-> $past(wake_wr))
    else $error("clock stop dropped without wake write");
  a_stop_refuse: assert property (CLK_STOP && cmd_wr |=> !WDT_CLEAR && !PRESCALER_CLEAR)
    else $error("command acted while clock stopped");
  a_tbl_cause: assert property (!$stable(TABLE_ADDR) |-> $past(tbl_wr))
    else $error("table address moved without table read");
  a_tbl_last: assert property (!$stable(TABLE_ADDR) && $past(trdl_wr)
    |-> TABLE_ADDR[12:8] == `ITF_LAST_PAGE)
    else $error("last page read outside last page");

  // main scenarios reached
  c_wdclr: cover property (WDT_CLEAR);
  c_halt: cover property (PRESCALER_CLEAR);
  c_wake: cover property ($fell(CLK_STOP));
  c_last: cover property (!$stable(TABLE_ADDR) && TABLE_ADDR[12:8] == `ITF_LAST_PAGE);
endmodule

bind itf_core itf_core_props i_itf_core_props (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WDT_TIMEOUT(WDT_TIMEOUT),
  .WDT_CLEAR(WDT_CLEAR), .PRESCALER_CLEAR(PRESCALER_CLEAR), .CLK_STOP(CLK_STOP),
  .TABLE_ADDR(TABLE_ADDR));

// ===== testbench/tb_top.sv
// self-checking bench for the instruction timing unit, random and directed commands
// assumes read data one clock after the read strobe and a status busy bit
`timescale 1ns/1ps
`include "itf_consts.vh"

module tb_top;
  reg         CLK, RESETN, WR, RD, WDT_TIMEOUT;
  reg  [7:0]  ADDR;
  reg  [31:0] WDATA;
  wire [31:0] RDATA;
  wire        WDT_CLEAR, PRESCALER_CLEAR, CLK_STOP;
  wire [12:0] TABLE_ADDR;
  integer     num_errors, checked, seed, cycles, i;
  reg  [31:0] d;
  reg  [15:0] t;
  reg  [9:0]  v;
  reg  [7:0]  m, a;
  reg  [5:0]  op;
  reg  [2:0]  b;
  reg  [4:0]  pg;
  reg         c, p;

  itf_core i_itf_core (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .WDT_TIMEOUT(WDT_TIMEOUT), .WDT_CLEAR(WDT_CLEAR),
    .PRESCALER_CLEAR(PRESCALER_CLEAR), .CLK_STOP(CLK_STOP), .TABLE_ADDR(TABLE_ADDR));

  // 100 MHz clock
  always #5 CLK = ~CLK;

  // hang guard; the run needs some 3000 cycles
  always @(posedge CLK)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      conclude;
    end
  end

  task conclude;
  begin
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // write; a clock passes before the next strobe
  task wr(input [7:0] ad, input [31:0] wd);
  begin
    @(posedge CLK);
    ADDR  <= ad;
    WDATA <= wd;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  end
  endtask

  // read; data taken in the cycle after the strobe
  task rd(input [7:0] ad, output [31:0] rv);
  begin
    @(posedge CLK);
    ADDR <= ad;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1;
    rv = RDATA;
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp, input [8*8-1:0] what);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t %0s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  // issue a command, then poll busy with a bound
  task run(input [5:0] o, input pc, input [2:0] bi);
    integer k;
  begin
    wr(`ITF_REG_CMD, {20'h0, pc, bi, 2'b00, o});
    d = 32'h1;
    for (k = 0; k < 20 && d[`ITF_ST_BUSY] !== 1'b0; k = k + 1)
      rd(`ITF_REG_STAT, d);
    chk(d & 32'h1, 32'h0, "busy");
  end
  endtask

  // timeout and power-down bits of status
  task flags(input [31:0] exp);
  begin
    rd(`ITF_REG_STAT, d);
    chk(d & 32'hC, exp, "wdflags");
  end
  endtask

  task tmo;
  begin
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b1;
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b0;
  end
  endtask

  // {writes, to acc, value}; no write gives 0 in the top bit
  function [9:0] eval(input [5:0] o, input [7:0] mv, input [7:0] av, input cv,
                      input [2:0] bi, input [15:0] tv);
  begin
    case (o)
      `ITF_OP_RR:    eval = {2'b10, mv[0], mv[7:1]};
      `ITF_OP_RRA:   eval = {2'b11, mv[0], mv[7:1]};
      `ITF_OP_RRC:   eval = {2'b10, cv, mv[7:1]};
      `ITF_OP_RRCA:  eval = {2'b11, cv, mv[7:1]};
      `ITF_OP_RL:    eval = {2'b10, mv[6:0], mv[7]};
      `ITF_OP_RLA:   eval = {2'b11, mv[6:0], mv[7]};
      `ITF_OP_RLC:   eval = {2'b10, mv[6:0], cv};
      `ITF_OP_RLCA:  eval = {2'b11, mv[6:0], cv};
      `ITF_OP_MOVMA: eval = {2'b10, av};
      `ITF_OP_CLRB:  eval = {2'b10, mv & ~(8'h01 << bi)};
      `ITF_OP_SETB:  eval = {2'b10, mv | (8'h01 << bi)};
      `ITF_OP_SIZ:   eval = {2'b10, mv + 8'h01};
      `ITF_OP_SDZ:   eval = {2'b10, mv - 8'h01};
      `ITF_OP_SIZA:  eval = {2'b11, mv + 8'h01};
      `ITF_OP_SDZA:  eval = {2'b11, mv - 8'h01};
      `ITF_OP_TRDC, `ITF_OP_TRDL: eval = {2'b10, tv[7:0]};
      `ITF_OP_CLRM:  eval = {2'b10, 8'h00};
      `ITF_OP_SETM:  eval = {2'b10, 8'hFF};
      `ITF_OP_SWAP:  eval = {2'b10, mv[3:0], mv[7:4]};
      `ITF_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR: eval = {2'b11, mv[3:0], mv[7:4]};
      `ITF_OP_MOVAM, `ITF_OP_MOVAX, `ITF_OP_SZA: eval = {2'b11, mv};
      default:       eval = {2'b00, av};
    endcase
  end
  endfunction

  // system clocks: base, pc low load penalty, taken skip penalty
  function [3:0] ecyc(input [5:0] o, input [7:0] mv, input pc, input [2:0] bi,
                      input [9:0] vv);
    reg sk, two;
  begin
    sk  = (o == `ITF_OP_SZ || o == `ITF_OP_SZA) ? (mv == 8'h00) :
          (o == `ITF_OP_SZB) ? !mv[bi] : (o == `ITF_OP_SNZB) ? mv[bi] :
          (o == `ITF_OP_SIZ || o == `ITF_OP_SIZA) ? (mv == 8'hFF) :
          (o == `ITF_OP_SDZ || o == `ITF_OP_SDZA) ? (mv == 8'h01) : 1'b0;
    two = (o >= `ITF_OP_CALL && o <= `ITF_OP_TRDL) || o == `ITF_OP_JMP;
    ecyc = {2'h1 + two + (vv[9] & ~vv[8] & pc) + sk, 2'b00};
  end
  endfunction

  initial
  begin
    CLK = 1'b0;
    RESETN = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    WDT_TIMEOUT = 1'b0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    seed = 92;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    rd(`ITF_REG_ACC, d);
    chk(d, {24'h0, `ITF_RST_ACC}, "acc rst");
    rd(`ITF_REG_PC, d);
    chk(d, {19'h0, `ITF_RST_PC}, "pc rst");
    rd(8'h3C, d);
    chk(d, 32'h0, "unmapped");
    // sweep every code except the watchdog and power-down ones once, then random; operands favour skip boundaries
    for (i = 0; i < 110; i = i + 1)
    begin
      op = (i < 33) ? i : {$random(seed)} % 33;
      if (op > 6'h1E)
        op = op + 6'h03;
      m = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'hFF : (i % 4 == 2) ? 8'h01 : $random(seed);
      a = $random(seed);
      t = $random(seed);
      b = $random(seed);
      p = $random(seed);
      c = $random(seed);
      wr(`ITF_REG_ACC, {24'h0, a});
      wr(`ITF_REG_OPND, {24'h0, m});
      wr(`ITF_REG_TBL, {16'h0, t});
      wr(`ITF_REG_CTRL, {29'h0, 1'b1, c, 1'b0});
      v = eval(op, m, a, c, b, t);
      rd(`ITF_REG_PC, d);
      pg = d[12:8];
      run(op, p, b);
      rd(`ITF_REG_CYC, d);
      chk(d & 32'hF, {28'h0, ecyc(op, m, p, b, v)}, "cycles");
      if (op == `ITF_OP_RRC || op == `ITF_OP_RRCA)
        c = m[0];
      if (op == `ITF_OP_RLC || op == `ITF_OP_RLCA)
        c = m[7];
      rd(`ITF_REG_STAT, d);
      chk(d & 32'h10E, {23'h0, v[9] & ~v[8], 6'h0, c, 1'b0}, "flags");
      if (v[9])
      begin
        rd(v[8] ? `ITF_REG_ACC : `ITF_REG_RES, d);
        chk(d & 32'hFF, {24'h0, v[7:0]}, "value");
      end
      if (op == `ITF_OP_TRDC || op == `ITF_OP_TRDL)
      begin
        rd(`ITF_REG_TBL, d);
        chk(d & 32'hFF, {24'h0, t[15:8]}, "tblhigh");
        chk({19'h0, TABLE_ADDR}, {19'h0, (op == `ITF_OP_TRDL) ? `ITF_LAST_PAGE : pg, a},
            "tbladdr");
      end
    end
    // a command while busy is dropped
    wr(`ITF_REG_CMD, 32'h0);
    run(`ITF_OP_SWAP, 1'b0, 3'h0);
    rd(`ITF_REG_CMD, d);
    chk(d & 32'h3F, 32'h0, "dropped");
    // preclears: one alone holds, the pair clears, in both orders
    tmo;
    run(`ITF_OP_WDT1, 1'b0, 3'h0);
    flags(32'h4);
    run(`ITF_OP_WDT2, 1'b0, 3'h0);
    flags(32'h0);
    tmo;
    run(`ITF_OP_WDT2, 1'b0, 3'h0);
    run(`ITF_OP_WDT2, 1'b0, 3'h0);
    flags(32'h4);
    run(`ITF_OP_WDT1, 1'b0, 3'h0);
    flags(32'h0);
    // power-down with timeout pending, a refused command, then wake
    tmo;
    run(`ITF_OP_HALT, 1'b0, 3'h0);
    flags(32'h8);
    chk({31'h0, CLK_STOP}, 32'h1, "stopped");
    rd(`ITF_REG_CYC, d);
    chk(d & 32'hF, 32'h4, "haltcyc");
    wr(`ITF_REG_CMD, {26'h0, `ITF_OP_CLRWDT});
    flags(32'h8);
    wr(`ITF_REG_CTRL, 32'h1);
    #1;
    chk({31'h0, CLK_STOP}, 32'h0, "woken");
    run(`ITF_OP_CLRWDT, 1'b0, 3'h0);
    flags(32'h0);
    conclude;
  end
endmodule
